// >>> inc/monitor_cfg_pkg.sv
/*
 * constants for the self-monitoring configuration registers and the
 * missing-host watchdog: offsets, field positions, reset values, timeouts.
 * assumes an 8-bit register address and 16-bit register data.
 */
package monitor_cfg_pkg;

    // register offsets
    localparam logic [7:0] DEV_MON_OFFSET = 8'h40;
    localparam logic [7:0] SUP_EN_OFFSET = 8'h41;
    localparam logic [7:0] SUP_TH_OFFSET = 8'h42;

    // device monitor config fields
    localparam int TIMEOUT_SEL_LSB = 0;
    localparam int OUT_POL_BIT = 2;
    localparam logic [15:0] DEV_MON_RESET = 16'h0000;
    localparam logic [1:0] TIMEOUT_OFF = 2'h0;
    localparam logic [1:0] TIMEOUT_SHORT = 2'h1;
    localparam logic [1:0] TIMEOUT_MID = 2'h2;
    localparam logic [1:0] TIMEOUT_LONG = 2'h3;

    // supply monitor enable register: all bits writable
    localparam logic [15:0] SUP_EN_RESET = 16'h0000;
    localparam logic [15:0] SUP_EN_MASK = 16'hffff;

    // threshold register fields
    localparam int IO_OV_LEVEL_BIT = 13;
    localparam int IO_UV_LEVEL_BIT = 12;
    localparam int ANALOG_HOT_LSB = 6;
    localparam int IO_HOT_LSB = 4;
    localparam logic [15:0] SUP_TH_RESET = 16'h10f0;
    localparam logic [15:0] SUP_TH_MASK = 16'h30f0;

    // watchdog timeouts in diagnostic oscillator periods
    localparam int TIMEOUT_SHORT_TICKS = 5120;
    localparam int TIMEOUT_MID_TICKS = 10240;
    localparam int TIMEOUT_LONG_TICKS = 20480;

endpackage

// >>> logic/host_loss_timer.sv
/*
 * missing-host watchdog counter, counting diagnostic oscillator ticks.
 * assumes tick_i is a one-cycle pulse per oscillator period, synchronous
 * to core_clk_i.
 */
`timescale 1ns/1ps
module host_loss_timer #(
    parameter int CNT_W = 15,
    parameter int SHORT_TICKS = 5120,
    parameter int MID_TICKS = 10240,
    parameter int LONG_TICKS = 20480
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] timeout_sel_i,
    input wire logic restart_i,
    input wire logic tick_i,
    output logic expire_o
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;

    if (LONG_TICKS >= (1 << CNT_W) || SHORT_TICKS < 1 || MID_TICKS < 1) begin : g_chk
        $error("host_loss_timer: timeout does not fit the counter");
    end

    // terminal count for the selected window
    always_comb begin
        case (timeout_sel_i)
            monitor_cfg_pkg::TIMEOUT_SHORT: limit = CNT_W'(SHORT_TICKS - 1);
            monitor_cfg_pkg::TIMEOUT_MID: limit = CNT_W'(MID_TICKS - 1);
            monitor_cfg_pkg::TIMEOUT_LONG: limit = CNT_W'(LONG_TICKS - 1);
            default: limit = '0;
        endcase
    end

    // count ticks; cleared while off, on restart and on expiry
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (timeout_sel_i == monitor_cfg_pkg::TIMEOUT_OFF || restart_i) begin
            count <= '0;
        end else if (tick_i) begin
            if (count == limit) begin
                count <= '0;
            end else begin
                count <= count + CNT_W'(1);
            end
        end
    end

    // one-cycle expiry pulse
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            expire_o <= 1'b0;
        end else begin
            expire_o <= (timeout_sel_i != monitor_cfg_pkg::TIMEOUT_OFF) && !restart_i
                && tick_i && (count == limit);
        end
    end

endmodule

// >>> logic/monitor_cfg_host_watchdog.sv
/*
 * self-monitoring configuration registers and missing-host watchdog.
 * assumes the command decoder delivers register accesses as single-cycle
 * strobes and pulses cmd_ok_i for every command whose crc checked good.
 */
`timescale 1ns/1ps
module monitor_cfg_host_watchdog #(
    parameter int SHORT_TICKS = monitor_cfg_pkg::TIMEOUT_SHORT_TICKS,
    parameter int MID_TICKS = monitor_cfg_pkg::TIMEOUT_MID_TICKS,
    parameter int LONG_TICKS = monitor_cfg_pkg::TIMEOUT_LONG_TICKS
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic cmd_ok_i,
    input wire logic diag_osc_tick_i,
    output logic host_loss_fault_pin_o,
    output logic host_loss_fault_o,
    output logic [15:0] monitor_enables_o,
    output logic io_ldo_overvolt_level_o,
    output logic io_ldo_undervolt_level_o,
    output logic [1:0] analog_ldo_hot_warn_level_o,
    output logic [1:0] io_ldo_hot_warn_level_o
);

    ////////////////////////////////////////////////////////////////////////
    // parameter checks

    // width of the watchdog counter; the longest window must stay below its wrap
    localparam int TIMER_W = 15;

    // refuse an empty window, or one the counter cannot reach before wrapping;
    // shortened windows are fine for simulation as long as they stay in range
    if (SHORT_TICKS < 1 || MID_TICKS < 1 || LONG_TICKS < 1
        || LONG_TICKS >= (1 << TIMER_W)) begin : g_param_chk
        $error("monitor_cfg_host_watchdog: watchdog window out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes
    //   40h device monitor config: bit 2 output polarity, bits 1:0 timeout code,
    //       bits 15:3 read as zero and ignore writes
    //   41h supply monitor enables, all sixteen bits writable
    //   42h supply monitor thresholds, bits 13, 12 and 7:4 writable
    // writes land on the strobe edge; nothing is buffered beyond the register

    logic [1:0] host_loss_timeout_sel;
    logic host_loss_out_polarity;
    logic [15:0] supply_monitor_enables;
    logic [15:0] supply_monitor_thresholds;
    logic wr_dev;
    logic wr_en;
    logic wr_th;
    logic sel_clear;
    logic restart;
    logic expire;

    // write decodes, one per register, plus the clearing write of the watchdog
    assign wr_dev = reg_wr_i && reg_addr_i == monitor_cfg_pkg::DEV_MON_OFFSET;
    assign wr_en = reg_wr_i && reg_addr_i == monitor_cfg_pkg::SUP_EN_OFFSET;
    assign wr_th = reg_wr_i && reg_addr_i == monitor_cfg_pkg::SUP_TH_OFFSET;
    assign sel_clear = wr_dev
        && reg_wdata_i[monitor_cfg_pkg::TIMEOUT_SEL_LSB +: 2] == monitor_cfg_pkg::TIMEOUT_OFF;

    // watchdog timeout and output polarity fields
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            host_loss_timeout_sel <= monitor_cfg_pkg::DEV_MON_RESET[1:0];
            host_loss_out_polarity <= monitor_cfg_pkg::DEV_MON_RESET[monitor_cfg_pkg::OUT_POL_BIT];
        end else if (wr_dev) begin
            host_loss_timeout_sel <= reg_wdata_i[monitor_cfg_pkg::TIMEOUT_SEL_LSB +: 2];
            host_loss_out_polarity <= reg_wdata_i[monitor_cfg_pkg::OUT_POL_BIT];
        end
    end

    // monitor enables, one bit per analog monitor, 1 turns the monitor on:
    //   15 analog_ldo_overvolt_on
    //   14 analog_ldo_undervolt_on
    //   13 io_ldo_overvolt_on
    //   12 io_ldo_undervolt_on
    //   11 digital_ldo_overvolt_on
    //   10 digital_ldo_undervolt_on
    //   9 analog_ldo_oscillation_on
    //   8 io_ldo_oscillation_on
    //   7 digital_ldo_oscillation_on
    //   6 analog_ldo_hot_warn_on
    //   5 io_ldo_hot_warn_on
    //   4 analog_ldo_current_limit_on
    //   3 io_ldo_current_limit_on
    //   2 analog_gnd_a_open_on
    //   1 analog_gnd_b_open_on
    //   0 digital_gnd_open_on
    // every monitor starts disabled, so turning one on is always a host decision
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            supply_monitor_enables <= monitor_cfg_pkg::SUP_EN_RESET;
        end else if (wr_en) begin
            supply_monitor_enables <= reg_wdata_i & monitor_cfg_pkg::SUP_EN_MASK;
        end
    end

    // thresholds; reserved bits stay zero:
    //   13 io_ldo_overvolt_level, 0 for 5.7 V, 1 for 3.9 V
    //   12 io_ldo_undervolt_level, 0 for 4.3 V, 1 for 2.95 V
    //   7:6 analog_ldo_hot_warn_level and 5:4 io_ldo_hot_warn_level:
    //       00b -60 C, 01b 100 C, 10b 120 C, 11b 140 C
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            supply_monitor_thresholds <= monitor_cfg_pkg::SUP_TH_RESET;
        end else if (wr_th) begin
            supply_monitor_thresholds <= reg_wdata_i & monitor_cfg_pkg::SUP_TH_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads, one cycle after the strobe; unmapped reads zero

    // read data is registered and held until the next read strobe, so the
    // host may take it any time after the edge that follows its strobe
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                monitor_cfg_pkg::DEV_MON_OFFSET:
                    reg_rdata_o <= {13'h0, host_loss_out_polarity, host_loss_timeout_sel};
                monitor_cfg_pkg::SUP_EN_OFFSET: reg_rdata_o <= supply_monitor_enables;
                monitor_cfg_pkg::SUP_TH_OFFSET: reg_rdata_o <= supply_monitor_thresholds;
                default: reg_rdata_o <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // missing-host watchdog

    // any good command or any write to the device monitor config (40h) restarts the window; a change of
    // code never inherits a partly spent window from the previous code
    assign restart = cmd_ok_i || wr_dev;

    // the expiry pulse follows the edge of the last tick of the window; the
    // fault rises one edge later and the pin one edge after that
    host_loss_timer #(
        .CNT_W(TIMER_W),
        .SHORT_TICKS(SHORT_TICKS),
        .MID_TICKS(MID_TICKS),
        .LONG_TICKS(LONG_TICKS)
    ) u_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .timeout_sel_i(host_loss_timeout_sel),
        .restart_i(restart),
        .tick_i(diag_osc_tick_i),
        .expire_o(expire)
    );

    // sticky fault: expiry sets it and wins over a same-cycle clear, so a
    // host that clears just as the window runs out sees the fault stay set
    // and must write 00b once more; losing an expiry would hide a host loss
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            host_loss_fault_o <= 1'b0;
        end else if (expire) begin
            host_loss_fault_o <= 1'b1;
        end else if (sel_clear) begin
            host_loss_fault_o <= 1'b0;
        end
    end

    // pin level: polarity 1 drives high on fault, 0 drives low on fault;
    // in reset the polarity is 0 and no fault stands, so the pin rests high
    // and a host watching it sees no false alarm while the block starts
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            host_loss_fault_pin_o <= 1'b1;
        end else begin
            host_loss_fault_pin_o <= ~(host_loss_fault_o ^ host_loss_out_polarity);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration outputs toward the analog monitors

    // registered copies keep the analog side off the write path, at the cost
    // of one cycle between a write and the monitor seeing it
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            monitor_enables_o <= monitor_cfg_pkg::SUP_EN_RESET;
            io_ldo_overvolt_level_o <=
                monitor_cfg_pkg::SUP_TH_RESET[monitor_cfg_pkg::IO_OV_LEVEL_BIT];
            io_ldo_undervolt_level_o <=
                monitor_cfg_pkg::SUP_TH_RESET[monitor_cfg_pkg::IO_UV_LEVEL_BIT];
            analog_ldo_hot_warn_level_o <=
                monitor_cfg_pkg::SUP_TH_RESET[monitor_cfg_pkg::ANALOG_HOT_LSB +: 2];
            io_ldo_hot_warn_level_o <=
                monitor_cfg_pkg::SUP_TH_RESET[monitor_cfg_pkg::IO_HOT_LSB +: 2];
        end else begin
            monitor_enables_o <= supply_monitor_enables;
            io_ldo_overvolt_level_o <=
                supply_monitor_thresholds[monitor_cfg_pkg::IO_OV_LEVEL_BIT];
            io_ldo_undervolt_level_o <=
                supply_monitor_thresholds[monitor_cfg_pkg::IO_UV_LEVEL_BIT];
            analog_ldo_hot_warn_level_o <=
                supply_monitor_thresholds[monitor_cfg_pkg::ANALOG_HOT_LSB +: 2];
            io_ldo_hot_warn_level_o <=
                supply_monitor_thresholds[monitor_cfg_pkg::IO_HOT_LSB +: 2];
        end
    end

endmodule

// >>> tb/host_model.sv
/* host side of the register port: writes, reads and good commands.
   assumes the block samples its strobes on the rising clock edge. */
`timescale 1ns/1ps
module host_model (
    input wire logic clk_i,
    output logic [7:0] addr_o,
    output logic [15:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    output logic cmd_ok_o
);
    // idle bus, all strobes and the good-command line low
    initial begin
        addr_o = 8'h00;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
        cmd_ok_o = 1'b0;
    end
    // one access, then lines scrambled so stale data never passes
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
        @(negedge clk_i);
        {addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'b00};
    endtask
    // one good command restarts the watchdog
    task automatic cmd();
        @(negedge clk_i);
        cmd_ok_o = 1'b1;
        @(negedge clk_i);
        cmd_ok_o = 1'b0;
    endtask
endmodule

// >>> tb/monitor_cfg_props.sv
/* port checker for the monitor config block and its watchdog.
   assumes it is bound into monitor_cfg_host_watchdog. */
`timescale 1ns/1ps
module monitor_cfg_props #(
    parameter int SHORT_TICKS = 5,
    parameter int MID_TICKS = 10,
    parameter int LONG_TICKS = 20
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic cmd_ok_i,
    input wire logic diag_osc_tick_i,
    input wire logic host_loss_fault_pin_o,
    input wire logic host_loss_fault_o,
    input wire logic [15:0] monitor_enables_o,
    input wire logic io_ldo_overvolt_level_o,
    input wire logic io_ldo_undervolt_level_o,
    input wire logic [1:0] analog_ldo_hot_warn_level_o,
    input wire logic [1:0] io_ldo_hot_warn_level_o
);
    logic [15:0] en_q;
    logic [2:0] cfg_q;
    logic [15:0] cnt;
    int lim;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////
    // shadow state and ticks since the last restart
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {en_q, cfg_q, cnt} <= '0;
        end else begin
            if (reg_wr_i && reg_addr_i == 8'h41) en_q <= reg_wdata_i;
            if (reg_wr_i && reg_addr_i == 8'h40) cfg_q <= reg_wdata_i[2:0];
            cnt <= (cmd_ok_i || (reg_wr_i && reg_addr_i == 8'h40)) ? 16'h0000
                : cnt + 16'(diag_osc_tick_i);
        end
    end
    // window length of the current code, 0 when off
    assign lim = cfg_q[1:0] == 2'h3 ? LONG_TICKS : cfg_q[1:0] == 2'h2 ? MID_TICKS :
        cfg_q[1:0] == 2'h1 ? SHORT_TICKS : 0;
    sequence s_wr(logic [7:0] a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    ////////////////////////////////
    chk_en_read: assert property (reg_rd_i && reg_addr_i == 8'h41 |=>
        reg_rdata_o == $past(en_q)) else $error("enable readback differs");
    chk_unmapped_read: assert property (reg_rd_i
        && !(reg_addr_i inside {8'h40, 8'h41, 8'h42})
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    chk_en_follow: assert property (s_wr(8'h41) |=> ##1
        monitor_enables_o == $past(reg_wdata_i, 2)) else $error("enable outputs wrong");
    chk_th_follow: assert property (s_wr(8'h42) |=> ##1 {io_ldo_overvolt_level_o,
        io_ldo_undervolt_level_o, analog_ldo_hot_warn_level_o, io_ldo_hot_warn_level_o} ==
        {$past(reg_wdata_i[13:12], 2), $past(reg_wdata_i[7:4], 2)}) else $error("threshold wrong");
    chk_pin_level: assert property (host_loss_fault_pin_o ==
        ~($past(host_loss_fault_o) ^ $past(cfg_q[2]))) else $error("pin level wrong");
    chk_fault_hold: assert property (host_loss_fault_o && !(reg_wr_i
        && reg_addr_i == 8'h40 && reg_wdata_i[1:0] == 2'h0) |=> host_loss_fault_o)
        else $error("fault dropped");
    chk_no_early: assert property ($rose(host_loss_fault_o) |-> $past(lim) != 0
        && $past(cnt) >= $past(lim) && $past(cnt) <= $past(lim) + 2)
        else $error("fault at wrong time");
    chk_fault_rise: assert property (lim != 0 && cnt == lim + 4 |-> host_loss_fault_o)
        else $error("fault missing");
endmodule
bind monitor_cfg_host_watchdog monitor_cfg_props #(.SHORT_TICKS(SHORT_TICKS),
    .MID_TICKS(MID_TICKS), .LONG_TICKS(LONG_TICKS)) u_props (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cmd_ok_i(cmd_ok_i),
    .diag_osc_tick_i(diag_osc_tick_i), .host_loss_fault_pin_o(host_loss_fault_pin_o),
    .host_loss_fault_o(host_loss_fault_o), .monitor_enables_o(monitor_enables_o),
    .io_ldo_overvolt_level_o(io_ldo_overvolt_level_o),
    .io_ldo_undervolt_level_o(io_ldo_undervolt_level_o),
    .analog_ldo_hot_warn_level_o(analog_ldo_hot_warn_level_o),
    .io_ldo_hot_warn_level_o(io_ldo_hot_warn_level_o));

// >>> tb/tb.sv
/* self-checking bench for the monitor config block.
   assumes watchdog windows shortened to 5, 10 and 20 ticks. */
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_t;
    logic clk = 1'b0, rst = 1'b1, tick = 1'b1, wr, rd, cmd_ok, pin, fault, ov, uv;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, en;
    logic [1:0] ahot, iohot;
    int errors = 0, num_checks = 0;
    row_t rows [10] = '{'{1'b0, 8'h41, 16'h0, 16'h0}, '{1'b0, 8'h42, 16'h0, 16'h10f0},
        '{1'b0, 8'h40, 16'h0, 16'h0}, '{1'b1, 8'h41, 16'hffff, 16'hffff},
        '{1'b1, 8'h41, 16'h0001, 16'h0001}, '{1'b1, 8'h41, 16'h8000, 16'h8000},
        '{1'b1, 8'h42, 16'hffff, 16'h30f0}, '{1'b1, 8'h42, 16'h0000, 16'h0000},
        '{1'b1, 8'h40, 16'hfff8, 16'h0000}, '{1'b1, 8'h77, 16'h1234, 16'h0000}};
    always #50 clk = ~clk;
    host_model u_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .cmd_ok_o(cmd_ok));
    monitor_cfg_host_watchdog #(.SHORT_TICKS(5), .MID_TICKS(10), .LONG_TICKS(20)) u_dut (
        .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .cmd_ok_i(cmd_ok), .diag_osc_tick_i(tick),
        .host_loss_fault_pin_o(pin), .host_loss_fault_o(fault), .monitor_enables_o(en),
        .io_ldo_overvolt_level_o(ov), .io_ldo_undervolt_level_o(uv),
        .analog_ldo_hot_warn_level_o(ahot), .io_ldo_hot_warn_level_o(iohot));
    ////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // wait for the fault, then one cycle for the pin to follow
    task automatic wait_fault();
        for (int k = 0; k < 30 && fault !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // hang guard, far above the expected run length
    initial begin
        #200000;
        errors++;
        stop_test();
    end
    ////////////////////////////////
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check({14'h0, fault, pin}, 16'h0001);
        check(en, 16'h0000);
        check({10'h0, ov, uv, ahot, iohot}, 16'h001f);
        foreach (rows[i]) begin
            if (rows[i].w) u_host.xfer(1'b1, rows[i].a, rows[i].d);
            u_host.xfer(1'b0, rows[i].a, 16'h0000);
            check(rdata, rows[i].e);
        end
        // short window survives commands and a stalled oscillator
        u_host.xfer(1'b1, 8'h40, 16'h0001);
        repeat (6) u_host.cmd();
        tick = 1'b0;
        repeat (30) @(negedge clk);
        tick = 1'b1;
        check({14'h0, fault, pin}, 16'h0001);
        wait_fault();
        check({14'h0, fault, pin}, 16'h0002);
        u_host.xfer(1'b1, 8'h40, 16'h0002);
        repeat (20) @(negedge clk);
        check({14'h0, fault, pin}, 16'h0002);
        u_host.xfer(1'b1, 8'h40, 16'h0004);
        repeat (2) @(negedge clk);
        check({14'h0, fault, pin}, 16'h0000);
        // long window with active-high pin, then disabled
        u_host.xfer(1'b1, 8'h40, 16'h0007);
        repeat (15) @(negedge clk);
        check({14'h0, fault, pin}, 16'h0000);
        wait_fault();
        check({14'h0, fault, pin}, 16'h0003);
        u_host.xfer(1'b1, 8'h40, 16'h0000);
        repeat (60) @(negedge clk);
        check({14'h0, fault, pin}, 16'h0001);
        // expiry in the cycle of a clearing write keeps the fault set
        u_host.xfer(1'b1, 8'h40, 16'h0001);
        repeat (4) @(negedge clk);
        u_host.xfer(1'b1, 8'h40, 16'h0000);
        repeat (2) @(negedge clk);
        check({14'h0, fault, pin}, 16'h0002);
        u_host.xfer(1'b1, 8'h40, 16'h0000);
        repeat (2) @(negedge clk);
        check({14'h0, fault, pin}, 16'h0001);
        // reset in mid-run returns registers and outputs to their reset values
        u_host.xfer(1'b1, 8'h41, 16'h5a5a);
        u_host.xfer(1'b1, 8'h42, 16'h2040);
        u_host.xfer(1'b1, 8'h40, 16'h0004);
        repeat (2) @(negedge clk);
        check(en, 16'h5a5a);
        check({10'h0, ov, uv, ahot, iohot}, 16'h0024);
        check({14'h0, fault, pin}, 16'h0000);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        check(en, 16'h0000);
        check({10'h0, ov, uv, ahot, iohot}, 16'h001f);
        check({14'h0, fault, pin}, 16'h0001);
        u_host.xfer(1'b0, 8'h40, 16'h0000);
        check(rdata, 16'h0000);
        stop_test();
    end
endmodule
